// ---- inc/atc_pkg.sv ----
package atc_pkg;

	// ****************************************
	// Register map
	// ****************************************
	localparam logic [7:0] ATC_CTRL_ADDR = 8'h91;
	localparam logic [7:0] ATC_CTRL_RESET = 8'h00;
	localparam int ATC_HI_FLAG_BIT = 7;
	localparam int ATC_LO_FLAG_BIT = 6;
	localparam int ATC_LO_IEN_BIT = 5;
	localparam int ATC_CAP_EN_BIT = 4;
	localparam int ATC_SPLIT_BIT = 3;
	localparam int ATC_RUN_BIT = 2;
	localparam int ATC_CLKSEL_LSB = 0;
	localparam logic [7:0] ATC_BYTE_MAX = 8'hff;
	localparam logic [7:0] ATC_BYTE_ZERO = 8'h00;
	localparam logic [15:0] ATC_COUNT_RESET = 16'h0000;

	typedef struct packed {
		logic high_overflow_flag;
		logic low_overflow_flag;
		logic low_byte_irq_enable;
		logic capture_mode_enable;
		logic split_mode_select;
		logic upper_run_control;
		logic [1:0] alt_clock_select;
	} atc_ctrl_t;

	// Count path events towards the control logic
	typedef struct packed {
		logic hi_wrap;
		logic lo_wrap;
		logic capture;
	} atc_evt_t;

	typedef enum logic [1:0] {
		ATC_MODE_WIDE = 2'b00,
		ATC_MODE_SPLIT = 2'b01,
		ATC_MODE_CAPTURE = 2'b11
	} atc_mode_t;

endpackage : atc_pkg

// ---- logic/atc_counter.sv ----
`timescale 1ns/100ps
module atc_counter (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic tick_hi,
	input wire logic tick_lo,
	input wire logic cap_trig,
	input atc_pkg::atc_mode_t mode,
	input wire logic run,
	input wire logic [15:0] reload_in,
	output logic [15:0] count,
	output logic [15:0] capture_val,
	output atc_pkg::atc_evt_t evt
);
	typedef struct packed {
		logic [15:0] count;
		logic [15:0] capture_val;
		atc_pkg::atc_evt_t evt;
	} atc_cnt_state_t;

	atc_cnt_state_t state;
	atc_cnt_state_t next_state;

	always_comb begin
		next_state = state;
		next_state.evt = '0;
		case (mode)
			atc_pkg::ATC_MODE_SPLIT: begin
				// Low byte always runs, high byte gated by run
				if (tick_lo) begin
					if (state.count[7:0] == atc_pkg::ATC_BYTE_MAX) begin
						next_state.count[7:0] = reload_in[7:0];
						next_state.evt.lo_wrap = 1'b1;
					end else begin
						next_state.count[7:0] = state.count[7:0] + 8'h01;
					end
				end
				if (tick_hi && run) begin
					if (state.count[15:8] == atc_pkg::ATC_BYTE_MAX) begin
						next_state.count[15:8] = reload_in[15:8];
						next_state.evt.hi_wrap = 1'b1;
					end else begin
						next_state.count[15:8] = state.count[15:8] + 8'h01;
					end
				end
			end
			default: begin
				if (tick_lo && run) begin
					next_state.evt.lo_wrap = (state.count[7:0] == atc_pkg::ATC_BYTE_MAX);
					if (state.count == 16'hffff) begin
						next_state.evt.hi_wrap = 1'b1;
						next_state.count = (mode == atc_pkg::ATC_MODE_CAPTURE) ?
							atc_pkg::ATC_COUNT_RESET : reload_in;
					end else begin
						next_state.count = state.count + 16'h0001;
					end
				end
				if (mode == atc_pkg::ATC_MODE_CAPTURE && cap_trig) begin
					next_state.capture_val = state.count;
					next_state.evt.capture = 1'b1;
				end
			end
		endcase
		if (!rst_b) begin
			next_state = '0;
		end
	end

	always_ff @(posedge clk) begin
		state <= next_state;
	end

	assign count = state.count;
	assign capture_val = state.capture_val;
	assign evt = state.evt;

endmodule : atc_counter

// ---- logic/atc_control.sv ----
`timescale 1ns/100ps
module atc_control (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic sfr_wr,
	input wire logic [7:0] sfr_addr,
	input wire logic [7:0] sfr_wdata,
	input wire logic timer_irq_enable,
	input wire logic tick_hi,
	input wire logic tick_lo,
	input wire logic cap_trig_pin,
	input wire logic [15:0] reload_value,
	output logic [7:0] ctrl_rdata,
	output logic irq_req,
	output logic [15:0] count_value,
	output logic capture_load,
	output logic [15:0] capture_value,
	output logic [1:0] alt_clock_select
);
	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		atc_pkg::atc_ctrl_t ctrl;
		logic irq_req;
		logic [2:0] trig_sync;
		logic trig_level;
		logic cap_edge;
		logic cap_load;
		logic [15:0] cap_val;
		logic [15:0] count_val;
	} atc_state_t;

	atc_state_t state;
	atc_state_t next_state;
	atc_pkg::atc_evt_t evt;
	atc_pkg::atc_mode_t mode;
	logic [15:0] count_int;
	logic [15:0] cap_int;
	logic ctrl_write;

	// ****************************************
	// Count path
	// ****************************************
	always_comb begin
		if (state.ctrl.capture_mode_enable) begin
			mode = atc_pkg::ATC_MODE_CAPTURE;
		end else if (state.ctrl.split_mode_select) begin
			mode = atc_pkg::ATC_MODE_SPLIT;
		end else begin
			mode = atc_pkg::ATC_MODE_WIDE;
		end
	end

	atc_counter u_counter (
		.clk(clk),
		.rst_b(rst_b),
		.tick_hi(tick_hi),
		.tick_lo(tick_lo),
		.cap_trig(state.cap_edge),
		.mode(mode),
		.run(state.ctrl.upper_run_control),
		.reload_in(reload_value),
		.count(count_int),
		.capture_val(cap_int),
		.evt(evt)
	);

	// Writes to any other address are dropped silently
	assign ctrl_write = sfr_wr && (sfr_addr == atc_pkg::ATC_CTRL_ADDR);

	// ****************************************
	// Control register and flags
	// ****************************************
	always_comb begin
		next_state = state;
		next_state.trig_sync = {state.trig_sync[1:0], cap_trig_pin};
		// Level accepted only once second and third stages agree
		if (state.trig_sync[1] == state.trig_sync[2]) begin
			next_state.trig_level = state.trig_sync[2];
		end
		// One pulse per accepted rise, however long the pin stays high
		next_state.cap_edge = state.trig_sync[1] && state.trig_sync[2] && !state.trig_level;
		if (ctrl_write) begin
			next_state.ctrl = atc_pkg::atc_ctrl_t'(sfr_wdata);
		end
		// Set wins over a same-cycle clear
		if (evt.hi_wrap || evt.capture) begin
			next_state.ctrl.high_overflow_flag = 1'b1;
		end
		if (evt.lo_wrap) begin
			next_state.ctrl.low_overflow_flag = 1'b1;
		end
		// Request follows the flag value now being registered
		next_state.irq_req = timer_irq_enable && (next_state.ctrl.high_overflow_flag
			|| (next_state.ctrl.low_byte_irq_enable
			&& next_state.ctrl.low_overflow_flag));
		// Output copies, so every port leaves a flip-flop
		next_state.cap_load = evt.capture;
		next_state.cap_val = cap_int;
		next_state.count_val = count_int;
		if (!rst_b) begin
			next_state = '0;
		end
	end

	always_ff @(posedge clk) begin
		state <= next_state;
	end

	assign ctrl_rdata = state.ctrl;
	assign irq_req = state.irq_req;
	assign alt_clock_select = state.ctrl.alt_clock_select;
	assign capture_load = state.cap_load;
	assign capture_value = state.cap_val;
	assign count_value = state.count_val;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	sequence hi_event;
		evt.hi_wrap || evt.capture;
	endsequence

	sequence trig_accepted;
		state.trig_sync[1] && state.trig_sync[2] && !state.trig_level;
	endsequence

	// ****************************************
	// Flags and interrupts
	// ****************************************
	chk_hi_flag_set: assert property (hi_event |=> state.ctrl.high_overflow_flag)
		else $error("high flag not set after wrap");
	chk_wide_wrap: assert property (mode == atc_pkg::ATC_MODE_WIDE && tick_lo
		&& state.ctrl.upper_run_control && count_int == 16'hffff
		|=> evt.hi_wrap && count_int == $past(reload_value))
		else $error("wide wrap missed");
	chk_irq_high: assert property (state.ctrl.high_overflow_flag
		&& $past(timer_irq_enable) |-> irq_req)
		else $error("interrupt missing for high flag");
	chk_irq_quiet: assert property (!state.ctrl.high_overflow_flag
		&& !(state.ctrl.low_overflow_flag && state.ctrl.low_byte_irq_enable) |-> !irq_req)
		else $error("interrupt without a flag");
	chk_flags_sticky: assert property (state.ctrl.low_overflow_flag && !ctrl_write
		|=> state.ctrl.low_overflow_flag)
		else $error("low flag cleared by hardware");
	chk_hi_sticky: assert property (state.ctrl.high_overflow_flag && !ctrl_write
		|=> state.ctrl.high_overflow_flag)
		else $error("high flag cleared by hardware");
	chk_lo_flag_set: assert property (evt.lo_wrap |=> state.ctrl.low_overflow_flag)
		else $error("low flag not set");
	chk_irq_low: assert property (state.ctrl.low_overflow_flag
		&& state.ctrl.low_byte_irq_enable && $past(timer_irq_enable) |-> irq_req)
		else $error("interrupt missing for low flag");
	chk_write_lands: assert property (ctrl_write
		|=> ctrl_rdata[5:0] == $past(sfr_wdata[5:0]))
		else $error("control write lost");
	chk_set_wins: assert property (ctrl_write && !sfr_wdata[7]
		&& (evt.hi_wrap || evt.capture) |=> state.ctrl.high_overflow_flag)
		else $error("event lost to clear");
	chk_reset_clear: assert property (disable iff (1'b0)
		!rst_b |=> state.ctrl == atc_pkg::ATC_CTRL_RESET)
		else $error("control register not cleared by reset");

	// ****************************************
	// Counting and capture
	// ****************************************
	chk_split_hi_wrap: assert property (mode == atc_pkg::ATC_MODE_SPLIT && tick_hi
		&& state.ctrl.upper_run_control && count_int[15:8] == atc_pkg::ATC_BYTE_MAX
		|=> evt.hi_wrap && count_int[15:8] == $past(reload_value[15:8]))
		else $error("upper byte wrap missed");
	chk_lo_wrap_wide: assert property (mode != atc_pkg::ATC_MODE_SPLIT && tick_lo
		&& state.ctrl.upper_run_control && count_int[7:0] == atc_pkg::ATC_BYTE_MAX
		|=> evt.lo_wrap)
		else $error("low wrap missed in wide mode");
	chk_lo_reload: assert property (mode == atc_pkg::ATC_MODE_SPLIT && tick_lo
		&& count_int[7:0] == atc_pkg::ATC_BYTE_MAX
		|=> evt.lo_wrap && count_int[7:0] == $past(reload_value[7:0]))
		else $error("low byte reload missed");
	chk_capture_mode: assert property (state.ctrl.capture_mode_enable
		|-> mode == atc_pkg::ATC_MODE_CAPTURE)
		else $error("capture mode not selected");
	chk_cap_refused: assert property (mode != atc_pkg::ATC_MODE_CAPTURE
		|=> !evt.capture)
		else $error("capture outside capture mode");
	chk_split_mode: assert property (!state.ctrl.capture_mode_enable
		&& state.ctrl.split_mode_select |-> mode == atc_pkg::ATC_MODE_SPLIT)
		else $error("split mode not selected");
	chk_wide_hold: assert property (mode != atc_pkg::ATC_MODE_SPLIT
		&& !state.ctrl.upper_run_control |=> $stable(count_int))
		else $error("counter moved while stopped");
	chk_trig_accept: assert property (trig_accepted |=> state.cap_edge)
		else $error("accepted trigger gave no edge");
	chk_edge_single: assert property (state.cap_edge |=> !state.cap_edge)
		else $error("trigger edge longer than one cycle");
	chk_capture_copy: assert property (evt.capture |=> capture_load
		&& capture_value == $past(cap_int))
		else $error("capture value not presented");
	chk_split_gate: assert property (mode == atc_pkg::ATC_MODE_SPLIT
		&& !state.ctrl.upper_run_control |=> $stable(count_int[15:8]))
		else $error("upper byte counted while stopped");
	chk_lo_free: assert property (mode == atc_pkg::ATC_MODE_SPLIT && tick_lo
		&& count_int[7:0] != atc_pkg::ATC_BYTE_MAX
		|=> count_int[7:0] == $past(count_int[7:0]) + 8'h01)
		else $error("low byte did not count in split mode");

endmodule : atc_control

// ---- sim/atc_tb.sv ----
`timescale 1ns/100ps
module testbench;
	logic clk, rst_b, sfr_wr, timer_irq_enable, tick_hi, tick_lo, cap_trig_pin;
	logic irq_req, capture_load;
	logic [7:0] sfr_addr, sfr_wdata, ctrl_rdata;
	logic [15:0] reload_value, count_value, capture_value;
	logic [1:0] alt_clock_select;
	int err_count = 0;
	int check_count = 0;
	atc_control u_dut (.clk(clk), .rst_b(rst_b), .sfr_wr(sfr_wr), .sfr_addr(sfr_addr),
		.sfr_wdata(sfr_wdata), .timer_irq_enable(timer_irq_enable), .tick_hi(tick_hi),
		.tick_lo(tick_lo), .cap_trig_pin(cap_trig_pin), .reload_value(reload_value),
		.ctrl_rdata(ctrl_rdata), .irq_req(irq_req), .count_value(count_value),
		.capture_load(capture_load), .capture_value(capture_value),
		.alt_clock_select(alt_clock_select));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task summarize;
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : summarize
	task step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : step
	task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task wr(input logic [7:0] a, input logic [7:0] d);
		sfr_wr = 1'b1;
		sfr_addr = a;
		sfr_wdata = d;
		step(1);
		sfr_wr = 1'b0;
		step(1);
	endtask : wr
	task ticks(input logic hi, input int n);
		tick_hi = hi;
		tick_lo = !hi;
		step(n);
		tick_hi = 1'b0;
		tick_lo = 1'b0;
		step(3);
	endtask : ticks
	// ****************************************
	// Scenarios
	// ****************************************
	task t_regs;
		chk("reset", 16'h0000, {8'h00, ctrl_rdata});
		wr(8'h91, 8'h3b);
		chk("ctrl", 16'h003b, {8'h00, ctrl_rdata});
		chk("clksel", 16'h0003, {14'h0000, alt_clock_select});
		wr(8'h92, 8'h00);
		chk("unmapped", 16'h003b, {8'h00, ctrl_rdata});
		$display("done regs");
	endtask : t_regs
	task t_wide;
		wr(8'h91, 8'h04);
		ticks(1'b0, 65536);
		step(50);
		chk("flags", 16'h00c4, {8'h00, ctrl_rdata});
		chk("reload", 16'hfff0, count_value);
		chk("irq", 16'h0001, {15'h0000, irq_req});
		timer_irq_enable = 1'b0;
		step(2);
		chk("irq off", 16'h0000, {15'h0000, irq_req});
		timer_irq_enable = 1'b1;
		wr(8'h91, 8'h04);
		chk("clear", 16'h0004, {8'h00, ctrl_rdata});
		ticks(1'b0, 15);
		chk("no early", 16'h0004, {8'h00, ctrl_rdata});
		chk("top", 16'hffff, count_value);
		tick_lo = 1'b1;
		step(1);
		tick_lo = 1'b0;
		sfr_wr = 1'b1;
		step(1);
		sfr_wr = 1'b0;
		step(3);
		chk("set wins", 16'h00c4, {8'h00, ctrl_rdata});
		chk("rewrap", 16'hfff0, count_value);
		$display("done wide");
	endtask : t_wide
	task t_split;
		wr(8'h91, 8'h08);
		ticks(1'b1, 1);
		ticks(1'b0, 16);
		chk("lo free", 16'h0048, {8'h00, ctrl_rdata});
		chk("no lo irq", 16'h0000, {15'h0000, irq_req});
		wr(8'h91, 8'h2c);
		ticks(1'b0, 16);
		chk("lo irq", 16'h0001, {15'h0000, irq_req});
		ticks(1'b1, 1);
		chk("hi wrap", 16'h00ec, {8'h00, ctrl_rdata});
		$display("done split");
	endtask : t_split
	task t_capture(input logic [7:0] mode, input logic exp);
		logic seen;
		seen = 1'b0;
		wr(8'h91, mode);
		cap_trig_pin = 1'b1;
		step(4);
		cap_trig_pin = 1'b0;
		for (int i = 0; i < 12; i++) begin
			seen |= capture_load;
			step(1);
		end
		chk("capture", {15'h0000, exp}, {15'h0000, seen});
		chk("cap flag", {15'h0000, exp}, {15'h0000, ctrl_rdata[7]});
		if (exp) chk("cap value", 16'hfff0, capture_value);
		$display("done capture");
	endtask : t_capture
	initial begin
		rst_b = 1'b0;
		sfr_wr = 1'b0;
		sfr_addr = 8'h00;
		sfr_wdata = 8'h00;
		timer_irq_enable = 1'b1;
		tick_hi = 1'b0;
		tick_lo = 1'b0;
		cap_trig_pin = 1'b0;
		reload_value = 16'hfff0;
		step(8);
		rst_b = 1'b1;
		t_regs();
		t_wide();
		t_split();
		t_capture(8'h08, 1'b0);
		t_capture(8'h14, 1'b1);
		summarize();
	end
endmodule : testbench
